/* File: include/cfs_consts.svh */
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH
// ----------------------------------------------------------------
// clock and bus timing
// ----------------------------------------------------------------
`define CFS_CORE_CLK_NS   10
`define CFS_SCL_STD_NS    10000
`define CFS_SCL_FAST_NS   2500
`define CFS_QTR_CYC       ((`CFS_SCL_STD_NS / 4) / `CFS_CORE_CLK_NS)
`define CFS_FILT_SAMPLES  2
// ----------------------------------------------------------------
// addressing and field values
// ----------------------------------------------------------------
`define CFS_ADDR_FIXED    4'hb
`define CFS_LVL_LOW       2'h0
`define CFS_LVL_OPEN      2'h1
`define CFS_LVL_HIGH      2'h2
`define CFS_BYTE_BITS     4'h8
`define CFS_MEM_AW        8
`define CFS_PTR_RST       16'h0000
`define CFS_STP_STOP_WR   3'h5
`define CFS_STP_STOP_RD   3'h7
`endif

/* File: include/cfs_pkg.sv */
package cfs_pkg;
   // slave byte engine states
   typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RACK, DS_TX, DS_TACK} cfs_dst_t;
   // meaning of the next received byte
   typedef enum logic [1:0] {DK_SLAVE, DK_PTRH, DK_PTRL, DK_DATA} cfs_kind_t;
   // master top level
   typedef enum logic {MS_IDLE, MS_RUN} cfs_mst_t;
   // master symbols
   typedef enum logic [1:0] {SY_START, SY_TXB, SY_RXB, SY_STOP} cfs_sym_t;
endpackage : cfs_pkg

/* File: include/cfs_if.sv */
`timescale 1ns/1ns
// open-drain two-wire bus; a line is low while any enabled driver pulls it
interface cfs_if;
   logic h_scl_o;
   logic h_scl_oe;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;
   // wired-and resolution with pull-ups
   assign scl = ~(h_scl_oe & ~h_scl_o);
   assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
   modport host (output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe, input scl, input sda);
   modport dev  (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface : cfs_if

/* File: src/cfs_sync.sv */
`timescale 1ns/1ns
`include "cfs_consts.svh"
// two-flop synchroniser and stability filter, one per bit
module cfs_sync #(
   parameter int         W       = 1,
   parameter int         FILT    = `CFS_FILT_SAMPLES,
   parameter bit [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic       meta;
         logic       stab;
         logic [3:0] cnt;
         wire        differ = stab ^ dout[g];
         // output follows only after FILT agreeing samples
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta    <= RST_VAL[g];
               stab    <= RST_VAL[g];
               cnt     <= 4'h0;
               dout[g] <= RST_VAL[g];
            end else begin
               meta <= din[g];
               stab <= meta;
               cnt  <= differ ? cnt + 4'h1 : 4'h0;
               if (differ && cnt == 4'(FILT - 1)) begin
                  dout[g] <= stab;
                  cnt     <= 4'h0;
               end
            end
         end
      end
   endgenerate
endmodule : cfs_sync

/* File: src/cfs_dev.sv */
`timescale 1ns/1ns
`include "cfs_consts.svh"
// ----------------------------------------------------------------
// configuration port slave
// ----------------------------------------------------------------
// What this block does
// - four-wire mode only when both straps high
// - address 1011 plus three strap-coded low bits
// - works at 100 kHz and 400 kHz
// - pure slave, never drives the clock line
// - data changes only while clock low
// - start condition begins a new transaction
// - stop condition returns the slave to idle
// - bytes are eight bits, msb first, plus ack
// - receiver acknowledges by pulling data low
// - not-acknowledge leaves data released high
// - first byte: address then direction bit
// - acknowledge only own address, else stay idle
// - write: two pointer bytes, high byte first
// - any number of write bytes, each acknowledged
// - read bytes are register contents
// - master nack ends read, slave releases data
// - repeated start accepts a new address byte
// - start or stop anywhere drops partial byte
// - port stays alive during chip power-down
// - write bytes go to successive addresses
// - plain read starts at current pointer
module cfs_dev #(
   parameter int MEM_AW = `CFS_MEM_AW
) (
   input  wire logic        core_clk,
   input  wire logic        link_clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  port_select_strap_hi,
   input  wire logic [1:0]  port_select_strap_lo,
   output logic             four_wire_sel,
   output logic             reg_wr,
   output logic [15:0]      reg_wr_addr,
   output logic [7:0]       reg_wr_data,
   cfs_if.dev               bus
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // three-level strap pair to a code, first strap most significant
   function automatic logic [2:0] strap_code(input logic [1:0] hi, input logic [1:0] lo);
      return 3'(4'(hi) * 4'h3 + 4'(lo));
   endfunction : strap_code
   // byte meaning after an acknowledged byte
   function automatic cfs_pkg::cfs_kind_t kind_after(input cfs_pkg::cfs_kind_t k);
      case (k)
         cfs_pkg::DK_SLAVE: return cfs_pkg::DK_PTRH;
         cfs_pkg::DK_PTRH:  return cfs_pkg::DK_PTRL;
         default:           return cfs_pkg::DK_DATA;
      endcase
   endfunction : kind_after
   // ----------------------------------------------------------------
   // line and strap sampling on the link clock
   // ----------------------------------------------------------------
   logic [1:0] line;
   logic [3:0] strap;
   logic       scl_d;
   logic       sda_d;
   logic [6:0] own_addr;
   cfs_sync #(.W(2), .FILT(`CFS_FILT_SAMPLES), .RST_VAL(2'h3)) u_line (
      .clk   (link_clk),
      .rst_n (rst_n),
      .din   ({bus.scl, bus.sda}),
      .dout  (line)
   );
   cfs_sync #(.W(4), .FILT(`CFS_FILT_SAMPLES), .RST_VAL(4'h0)) u_strap (
      .clk   (link_clk),
      .rst_n (rst_n),
      .din   ({port_select_strap_hi, port_select_strap_lo}),
      .dout  (strap)
   );
   // edge and condition decode on filtered lines
   wire scl      = line[1];
   wire sda      = line[0];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_c  = scl & scl_d & sda_d & ~sda;
   wire stop_c   = scl & scl_d & ~sda_d & sda;
   wire spi_sel  = (strap[3:2] == `CFS_LVL_HIGH) && (strap[1:0] == `CFS_LVL_HIGH);
   // straps are taken continuously once out of reset
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d         <= 1'b1;
         sda_d         <= 1'b1;
         four_wire_sel <= 1'b0;
         own_addr      <= 7'h00;
      end else begin
         scl_d         <= scl;
         sda_d         <= sda;
         four_wire_sel <= spi_sel;
         own_addr      <= {`CFS_ADDR_FIXED, strap_code(strap[3:2], strap[1:0])};
      end
   end
   // ----------------------------------------------------------------
   // byte engine
   // ----------------------------------------------------------------
   cfs_pkg::cfs_dst_t  st, next_st;
   cfs_pkg::cfs_kind_t kind, next_kind;
   logic [3:0]         bcnt, next_bcnt;
   logic [7:0]         sh, next_sh;
   logic [7:0]         tx, next_tx;
   logic               rw, next_rw;
   logic [15:0]        ptr, next_ptr;
   logic               drv, next_drv;
   logic               mem_we;
   logic [7:0]         mem [2**MEM_AW];
   logic               wr_tog;
   logic [15:0]        wr_addr_l;
   logic [7:0]         wr_data_l;
   wire [7:0] mem_rd   = mem[ptr[MEM_AW-1:0]];
   wire       byte_end = scl_fall && (bcnt == `CFS_BYTE_BITS);
   // next-state decode; no power-down input gates this logic
   always_comb begin
      next_st   = st;
      next_kind = kind;
      next_bcnt = bcnt;
      next_sh   = sh;
      next_tx   = tx;
      next_rw   = rw;
      next_ptr  = ptr;
      next_drv  = drv;
      mem_we    = 1'b0;
      if (four_wire_sel || stop_c) begin
         next_st  = cfs_pkg::DS_IDLE;
         next_drv = 1'b0;
      end else if (start_c) begin
         next_st   = cfs_pkg::DS_RX;
         next_kind = cfs_pkg::DK_SLAVE;
         next_bcnt = 4'h0;
         next_drv  = 1'b0;
      end else begin
         case (st)
            cfs_pkg::DS_RX: begin
               if (scl_rise && bcnt != `CFS_BYTE_BITS) begin
                  next_sh   = {sh[6:0], sda};
                  next_bcnt = bcnt + 4'h1;
               end else if (byte_end) begin
                  next_drv = 1'b1;
                  next_st  = cfs_pkg::DS_RACK;
                  case (kind)
                     cfs_pkg::DK_SLAVE: begin
                        next_rw = sh[0];
                        if (sh[7:1] != own_addr) begin
                           next_drv = 1'b0;
                           next_st  = cfs_pkg::DS_IDLE;
                        end
                     end
                     cfs_pkg::DK_PTRH: next_ptr[15:8] = sh;
                     cfs_pkg::DK_PTRL: next_ptr[7:0]  = sh;
                     default: begin
                        mem_we   = 1'b1;
                        next_ptr = ptr + 16'h0001;
                     end
                  endcase
               end
            end
            cfs_pkg::DS_RACK: begin
               if (scl_fall) begin
                  next_drv  = 1'b0;
                  next_bcnt = 4'h0;
                  if (kind == cfs_pkg::DK_SLAVE && rw) begin
                     next_st  = cfs_pkg::DS_TX;
                     next_tx  = mem_rd;
                     next_drv = ~mem_rd[7];
                  end else begin
                     next_st   = cfs_pkg::DS_RX;
                     next_kind = kind_after(kind);
                  end
               end
            end
            cfs_pkg::DS_TX: begin
               if (scl_rise) begin
                  next_bcnt = bcnt + 4'h1;
               end else if (byte_end) begin
                  next_drv = 1'b0;
                  next_st  = cfs_pkg::DS_TACK;
                  next_ptr = ptr + 16'h0001;
               end else if (scl_fall) begin
                  next_tx  = {tx[6:0], 1'b0};
                  next_drv = ~tx[6];
               end
            end
            cfs_pkg::DS_TACK: begin
               if (scl_rise) begin
                  next_sh[0] = sda;
               end else if (scl_fall) begin
                  next_bcnt = 4'h0;
                  if (sh[0]) begin
                     next_st = cfs_pkg::DS_IDLE;
                  end else begin
                     next_st  = cfs_pkg::DS_TX;
                     next_tx  = mem_rd;
                     next_drv = ~mem_rd[7];
                  end
               end
            end
            default: next_drv = 1'b0;
         endcase
      end
   end
   // engine state
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         st   <= cfs_pkg::DS_IDLE;
         kind <= cfs_pkg::DK_SLAVE;
         bcnt <= 4'h0;
         sh   <= 8'h00;
         tx   <= 8'h00;
         rw   <= 1'b0;
         ptr  <= `CFS_PTR_RST;
         drv  <= 1'b0;
      end else begin
         st   <= next_st;
         kind <= next_kind;
         bcnt <= next_bcnt;
         sh   <= next_sh;
         tx   <= next_tx;
         rw   <= next_rw;
         ptr  <= next_ptr;
         drv  <= next_drv;
      end
   end
   // register store, written only with whole acknowledged bytes
   always_ff @(posedge link_clk) begin
      if (mem_we) begin
         mem[ptr[MEM_AW-1:0]] <= sh;
      end
   end
   // write event: data held, toggle announces it
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_tog    <= 1'b0;
         wr_addr_l <= 16'h0000;
         wr_data_l <= 8'h00;
      end else if (mem_we) begin
         wr_tog    <= ~wr_tog;
         wr_addr_l <= ptr;
         wr_data_l <= sh;
      end
   end
   // slave only pulls data low; no clock output exists
   assign bus.d_sda_o  = 1'b0;
   assign bus.d_sda_oe = drv;
   // ----------------------------------------------------------------
   // crossing to the core clock
   // ----------------------------------------------------------------
   logic [2:0] tog_s;
   wire        wr_seen = tog_s[2] ^ tog_s[1];

   // toggle synchroniser; held words are stable long before it lands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_s       <= 3'h0;
         reg_wr      <= 1'b0;
         reg_wr_addr <= 16'h0000;
         reg_wr_data <= 8'h00;
      end else begin
         tog_s  <= {tog_s[1:0], wr_tog};
         reg_wr <= wr_seen;
         if (wr_seen) begin
            reg_wr_addr <= wr_addr_l;
            reg_wr_data <= wr_data_l;
         end
      end
   end
endmodule : cfs_dev

/* File: src/cfs_host.sv */
`timescale 1ns/1ns
`include "cfs_consts.svh"
// ----------------------------------------------------------------
// two-wire master: single-byte register write and read
// ----------------------------------------------------------------
module cfs_host #(
   parameter int QTR_CYC = `CFS_QTR_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_read,
   input  wire logic [6:0]  cmd_dev_addr,
   input  wire logic [15:0] cmd_reg_addr,
   input  wire logic [7:0]  cmd_wdata,
   output logic             rsp_valid,
   output logic             rsp_nack,
   output logic [7:0]       rsp_rdata,
   cfs_if.host              bus
);
   // symbol sequence of both command kinds
   function automatic cfs_pkg::cfs_sym_t sym_of(input logic rd, input logic [2:0] s);
      if (s == 3'h0 || (rd && s == 3'h4)) return cfs_pkg::SY_START;
      if (s == (rd ? `CFS_STP_STOP_RD : `CFS_STP_STOP_WR)) return cfs_pkg::SY_STOP;
      if (rd && s == 3'h6) return cfs_pkg::SY_RXB;
      return cfs_pkg::SY_TXB;
   endfunction : sym_of

   cfs_pkg::cfs_mst_t st;
   logic [2:0]        stp;
   logic [1:0]        q;
   logic [3:0]        bit_i;
   logic [15:0]       qcnt;
   logic              scl_oe;
   logic              sda_oe;
   logic              rd;
   logic [6:0]        dev;
   logic [15:0]       radr;
   logic [7:0]        wdat;
   logic [1:0]        sda_s;

   wire               qtick = (qcnt == 16'(QTR_CYC - 1));
   wire cfs_pkg::cfs_sym_t sym = sym_of(rd, stp);
   // address byte with direction, then pointer high and low bytes
   wire [7:0] tbyte = (stp == 3'h1 || stp == 3'h5) ? {dev, stp == 3'h5} :
                      (stp == 3'h2) ? radr[15:8] : (stp == 3'h3) ? radr[7:0] : wdat;
   wire       tbit  = tbyte[3'h7 - bit_i[2:0]];
   wire       last  = (bit_i == `CFS_BYTE_BITS);
   wire       sda_in = sda_s[1];

   // quarter-bit pacing and line sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= cfs_pkg::MS_IDLE;
         {stp, q, bit_i, qcnt} <= 25'h0;
         {scl_oe, sda_oe, rd, rsp_valid, rsp_nack} <= 5'h0;
         cmd_ready <= 1'b1;
         {dev, radr, wdat, rsp_rdata, sda_s} <= 41'h3;
      end else begin
         sda_s     <= {sda_s[0], bus.sda};
         rsp_valid <= 1'b0;
         if (st == cfs_pkg::MS_IDLE) begin
            if (cmd_valid && cmd_ready) begin
               st        <= cfs_pkg::MS_RUN;
               cmd_ready <= 1'b0;
               {rd, dev, radr, wdat} <= {cmd_read, cmd_dev_addr, cmd_reg_addr, cmd_wdata};
               {stp, q, bit_i, qcnt, rsp_nack} <= 26'h0;
            end
         end else begin
            qcnt <= qtick ? 16'h0000 : qcnt + 16'h0001;
            if (qtick) begin
               q <= q + 2'h1;
               case (q)
                  2'h0: begin                       // data moves while clock low
                     case (sym)
                        cfs_pkg::SY_START: sda_oe <= 1'b0;
                        cfs_pkg::SY_STOP:  sda_oe <= 1'b1;
                        cfs_pkg::SY_TXB:   sda_oe <= ~last & ~tbit;
                        default:           sda_oe <= 1'b0;
                     endcase
                  end
                  2'h1: scl_oe <= 1'b0;
                  2'h2: begin
                     case (sym)
                        cfs_pkg::SY_START: sda_oe <= 1'b1;
                        cfs_pkg::SY_STOP:  sda_oe <= 1'b0;
                        cfs_pkg::SY_RXB: if (!last) rsp_rdata <= {rsp_rdata[6:0], sda_in};
                        default: if (last && sda_in) rsp_nack <= 1'b1;
                     endcase
                  end
                  default: begin
                     if (sym == cfs_pkg::SY_STOP) begin
                        st        <= cfs_pkg::MS_IDLE;
                        cmd_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                     end else begin
                        scl_oe <= 1'b1;
                        if (sym == cfs_pkg::SY_START || last) begin
                           bit_i <= 4'h0;
                           stp   <= (sym == cfs_pkg::SY_TXB && sda_in) ?
                                    (rd ? `CFS_STP_STOP_RD : `CFS_STP_STOP_WR) : stp + 3'h1;
                        end else begin
                           bit_i <= bit_i + 4'h1;
                        end
                     end
                  end
               endcase
            end
         end
      end
   end

   assign bus.h_scl_o  = 1'b0;
   assign bus.h_scl_oe = scl_oe;
   assign bus.h_sda_o  = 1'b0;
   assign bus.h_sda_oe = sda_oe;
endmodule : cfs_host

/* File: testbench/cfs_sva.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// two-wire bus checker
// ----------------------------------------------------------------
module cfs_sva (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic h_scl_oe,
   input wire logic h_sda_oe,
   input wire logic d_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // clock line low only while the host pulls it
   a_scl_host_only: assert property (scl == !h_scl_oe)
      else $error("clock line not owned by host");
   // device data steady across a clock high period
   a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
      else $error("device moved data while clock high");
   // host data moves in clock high only as start or stop
   a_host_hold_high: assert property (scl && $past(scl) && $changed(h_sda_oe) |-> $changed(sda))
      else $error("host moved data while clock high");
   // device pull begins with room before the clock rises
   a_ack_setup: assert property ($rose(d_sda_oe) |-> !scl [*8])
      else $error("device pull too close to clock rise");
   // device pull is held, not a glitch
   a_ack_held: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
      else $error("device pull too short");
   // device lets go only while clock low
   a_dev_release: assert property ($fell(d_sda_oe) |-> !scl)
      else $error("device released data while clock high");
   // start leaves the device listening, not driving
   a_start_quiet: assert property (scl && $past(scl) && $fell(sda) |=> !d_sda_oe [*8])
      else $error("device drives after start");
   // stop returns the device to idle
   a_stop_quiet: assert property (scl && $past(scl) && $rose(sda) |=> !d_sda_oe [*8])
      else $error("device drives after stop");
endmodule : cfs_sva

/* File: testbench/i2c_config_slave_port_tb_top.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bench top: host and device joined on one bus
// ----------------------------------------------------------------
module i2c_config_slave_port_tb_top;
   logic        core_clk     = 1'b0;
   logic        link_clk     = 1'b0;
   logic        rst_n        = 1'b0;
   logic [1:0]  strap_hi     = 2'h0;
   logic [1:0]  strap_lo     = 2'h0;
   logic        cmd_valid    = 1'b0;
   logic        cmd_read     = 1'b0;
   logic [6:0]  cmd_dev_addr = 7'h00;
   logic [15:0] cmd_reg_addr = 16'h0000;
   logic [7:0]  cmd_wdata    = 8'h00;
   logic        cmd_ready;
   logic        rsp_valid;
   logic        rsp_nack;
   logic [7:0]  rsp_rdata;
   logic        four_wire_sel;
   logic        reg_wr;
   logic [15:0] reg_wr_addr;
   logic [7:0]  reg_wr_data;
   logic [9:0]  rsp_q[$];
   logic [23:0] wr_q[$];
   logic [9:0]  rsp_exp;
   logic [15:0] wa[9];
   logic [7:0]  wd[9];
   logic [31:0] rng          = 32'h00000008;
   int          err_count    = 0;
   int          n_tests      = 0;

   cfs_if bus_if ();
   cfs_dev #(.MEM_AW(8)) cfs_dev_i (.core_clk(core_clk), .link_clk(link_clk), .rst_n(rst_n),
      .port_select_strap_hi(strap_hi), .port_select_strap_lo(strap_lo), .four_wire_sel(four_wire_sel),
      .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .bus(bus_if.dev));
   cfs_host #(.QTR_CYC(40)) cfs_host_i (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr), .cmd_reg_addr(cmd_reg_addr),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata),
      .bus(bus_if.host));
   cfs_sva cfs_sva_i (.core_clk(core_clk), .rst_n(rst_n), .h_scl_oe(bus_if.h_scl_oe),
      .h_sda_oe(bus_if.h_sda_oe), .d_sda_oe(bus_if.d_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

   // core clock, and a link clock of unrelated phase
   always #5 core_clk = ~core_clk;
   initial begin
      #3;
      forever #40 link_clk = ~link_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // strap code 0..7 gives the low address bits
   function automatic logic [6:0] own_addr(input int c);
      return {4'hb, 3'(c)};
   endfunction : own_addr

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // one host command; expectation {check data, nack, data} noted first
   task automatic run_cmd(input logic rd, input logic [6:0] dev, input logic [15:0] ra, input logic [7:0] wv,
                          input logic [9:0] exp);
      int n;
      n = 0;
      rsp_q.push_back(exp);
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_dev_addr = dev;
      cmd_reg_addr = ra;
      cmd_wdata = wv;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      while (cmd_ready !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check("command done", 24'h1, {23'h0, cmd_ready});
      repeat (2) @(posedge core_clk);
      #1;
   endtask : run_cmd

   task automatic settle;
      repeat (20) @(posedge link_clk);
      @(posedge core_clk);
      #1;
   endtask : settle

   task automatic results;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // monitors: oldest note against each result
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rsp_valid === 1'b1) begin
         rsp_exp = (rsp_q.size() > 0) ? rsp_q.pop_front() : 10'hx;
         check("response nack", {23'h0, rsp_exp[8]}, {23'h0, rsp_nack});
         if (rsp_exp[9]) check("read data", {16'h0, rsp_exp[7:0]}, {16'h0, rsp_rdata});
      end
      if (reg_wr === 1'b1) begin
         check("register write", (wr_q.size() > 0) ? wr_q.pop_front() : 24'hx, {reg_wr_addr, reg_wr_data});
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      repeat (2) @(posedge link_clk);
      #1 rst_n = 1'b1;
      settle();
      // every strap pair: mode select and own-address write
      for (int i = 0; i < 9; i++) begin
         strap_hi = 2'(i / 3);
         strap_lo = 2'(i % 3);
         settle();
         check("four wire select", {23'h0, i == 8}, {23'h0, four_wire_sel});
         rng = xs(rng);
         wa[i] = {rng[15:8], 4'(i), rng[3:0]};
         wd[i] = rng[23:16];
         if (i < 8) wr_q.push_back({wa[i], wd[i]});
         run_cmd(1'b0, own_addr(i), wa[i], wd[i], {1'b0, i == 8, 8'h00});
      end
      strap_hi = 2'h1;
      strap_lo = 2'h0;
      settle();
      run_cmd(1'b0, own_addr(5), wa[1], 8'h5a, {2'b01, 8'h00});
      run_cmd(1'b1, own_addr(3), wa[0], 8'h00, {2'b10, wd[0]});
      run_cmd(1'b1, own_addr(3), wa[7], 8'h00, {2'b10, wd[7]});
      check("writes left", 24'h0, 24'(wr_q.size()));
      check("responses left", 24'h0, 24'(rsp_q.size()));
      results();
   end

   // watchdog
   initial begin
      #1000000;
      err_count++;
      $display("[ERR] run expected finish seen timeout");
      results();
   end
endmodule : i2c_config_slave_port_tb_top
